// ### rtl/pic_capture_channel.sv
// The address map and register access over APB were decided locally.
module pic_capture_channel
  import pic_pkg::*;
#(
  parameter int CNT_WIDTH = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_pin,
  output logic channel_timer_irq,
  output logic irq
);

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  logic [PIC_MODE_WIDTH-1:0] mode_r, mode_nxt;
  logic edge_valid;
  logic tick;

  pic_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in(capture_input_pin),
    .edge_sel(mode_r[PIC_MODE_EDGE_LSB +: 2]),
    .edge_valid(edge_valid)
  );

  pic_prescaler #(.DIV_WIDTH(15)) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .presc_sel(mode_r[PIC_MODE_PRESC_LSB +: 4]),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic acc, wr, rd;
  logic start_wr, stop_wr;
  logic trig_pin;

  always_comb begin
    acc = clk_en & psel & penable;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    start_wr = wr & (paddr == PIC_OFF_START) & pwdata[0];
    stop_wr = wr & (paddr == PIC_OFF_STOP) & pwdata[0];
    trig_pin = (mode_r[PIC_MODE_TRIG_LSB +: 2] == PIC_TRIG_PIN);
  end

  // ----------------------------------------------------------------
  // channel state, counter, capture
  // ----------------------------------------------------------------
  pic_state_type state_r, state_nxt;
  logic [CNT_WIDTH-1:0] count_r, count_nxt;
  logic [CNT_WIDTH-1:0] data_r, data_nxt;
  logic ovf_pend_r, ovf_pend_nxt;
  logic ovf_flag_r, ovf_flag_nxt;
  logic ev_capture, ev_start, ev_ovf;
  logic wrap;

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    data_nxt = data_r;
    ovf_pend_nxt = ovf_pend_r;
    ovf_flag_nxt = ovf_flag_r;
    ev_capture = 1'b0;
    ev_start = 1'b0;
    ev_ovf = 1'b0;
    wrap = tick & (count_r == {CNT_WIDTH{1'b1}});
    if (stop_wr) begin
      state_nxt = PIC_ST_IDLE;
    end else if (start_wr) begin
      // start clears the count; pin trigger waits for the first edge
      count_nxt = PIC_COUNT_ZERO[CNT_WIDTH-1:0];
      ovf_pend_nxt = 1'b0;
      ev_start = mode_r[PIC_MODE_START_IRQ_BIT];
      state_nxt = trig_pin ? PIC_ST_WAIT : PIC_ST_COUNT;
    end else begin
      case (state_r)
        PIC_ST_IDLE: begin
          state_nxt = PIC_ST_IDLE;
        end
        PIC_ST_WAIT: begin
          if (edge_valid) begin
            state_nxt = PIC_ST_COUNT;
            count_nxt = PIC_COUNT_ZERO[CNT_WIDTH-1:0];
          end
        end
        PIC_ST_COUNT: begin
          if (trig_pin && edge_valid) begin
            data_nxt = count_r;
            ev_capture = 1'b1;
            ovf_flag_nxt = ovf_pend_r | wrap;
            ovf_pend_nxt = 1'b0;
            count_nxt = PIC_COUNT_ZERO[CNT_WIDTH-1:0];
          end else if (tick) begin
            count_nxt = count_r + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            if (wrap) begin
              ovf_pend_nxt = 1'b1;
              ev_ovf = 1'b1;
            end
          end
        end
        default: state_nxt = PIC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PIC_ST_IDLE;
      count_r <= '0;
      data_r <= '0;
      ovf_pend_r <= 1'b0;
      ovf_flag_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      data_r <= data_nxt;
      ovf_pend_r <= ovf_pend_nxt;
      ovf_flag_r <= ovf_flag_nxt;
    end
  end

  // ----------------------------------------------------------------
  // mode, interrupt status and mask registers
  // ----------------------------------------------------------------
  logic [PIC_IRQ_WIDTH-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev_vec;
  logic tirq_r, tirq_nxt, irq_r, irq_nxt;

  always_comb begin
    mode_nxt = mode_r;
    imask_nxt = imask_r;
    ev_vec = '0;
    ev_vec[PIC_IRQ_CAPTURE] = ev_capture;
    ev_vec[PIC_IRQ_START] = ev_start;
    ev_vec[PIC_IRQ_OVERFLOW] = ev_ovf;
    ist_nxt = ist_r;
    if (wr && paddr == PIC_OFF_MODE) begin
      mode_nxt = pwdata[PIC_MODE_WIDTH-1:0];
    end
    if (wr && paddr == PIC_OFF_IRQ_MASK) begin
      imask_nxt = pwdata[PIC_IRQ_WIDTH-1:0];
    end
    if (wr && paddr == PIC_OFF_IRQ_STAT) begin
      ist_nxt = ist_r & ~pwdata[PIC_IRQ_WIDTH-1:0];
    end
    // a new event wins over a clear in the same cycle
    ist_nxt = ist_nxt | ev_vec;
    // one-cycle channel pulse on capture or enabled start
    tirq_nxt = clk_en ? (ev_capture | ev_start) : tirq_r;
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= PIC_MODE_RESET;
      imask_r <= '0;
      ist_r <= '0;
      tirq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      imask_r <= imask_nxt;
      ist_r <= ist_nxt;
      tirq_r <= tirq_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // apb read path, registered, zero wait states
  // ----------------------------------------------------------------
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic map_hit;

  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = clk_en ? 1'b0 : pslverr_r; // hold while frozen
    map_hit = 1'b1;
    if (clk_en && psel && !penable) begin
      prdata_nxt = PIC_RDATA_ZERO;
      case (paddr)
        PIC_OFF_MODE: prdata_nxt[PIC_MODE_WIDTH-1:0] = mode_r;
        PIC_OFF_START: prdata_nxt = PIC_RDATA_ZERO;
        PIC_OFF_STOP: prdata_nxt = PIC_RDATA_ZERO;
        PIC_OFF_STATUS: begin
          prdata_nxt[PIC_STAT_ENABLED] = (state_r != PIC_ST_IDLE);
          prdata_nxt[PIC_STAT_OVF] = ovf_flag_r;
        end
        PIC_OFF_COUNT: prdata_nxt[CNT_WIDTH-1:0] = count_r;
        PIC_OFF_DATA: prdata_nxt[CNT_WIDTH-1:0] = data_r;
        PIC_OFF_IRQ_STAT: prdata_nxt[PIC_IRQ_WIDTH-1:0] = ist_r;
        PIC_OFF_IRQ_MASK: prdata_nxt[PIC_IRQ_WIDTH-1:0] = imask_r;
        default: map_hit = 1'b0;
      endcase
      pslverr_nxt = ~map_hit;
    end else if (clk_en && psel && penable) begin
      pslverr_nxt = pslverr_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from flops, except pready which is clk_en itself
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign pready = clk_en; // ready whenever the block runs
  assign channel_timer_irq = tirq_r;
  assign irq = irq_r;

endmodule // pic_capture_channel

// ### rtl/pic_pkg.sv
// Notes on behaviour
// - once started in capture mode, counting begins on a valid input edge.
// - next valid edge captures the count, giving the interval between pulses.
// - writing one to the start bit enables counting and clears the count to zero.
// - with pin trigger, each valid edge after the starting one copies the count register into the data register.
// - the channel interrupt is raised when a capture completes.
// - after capture the count restarts at zero and keeps counting until the next edge.
// - the edge detector can select rising edges only as valid.
// - the capture trigger can be the valid edge of the input pin.
// - the operation clock is selectable, undivided clock included.
// - a trigger setting makes the pin edge both start and capture trigger.
// - a mode bit selects whether starting also raises the interrupt.
package pic_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PIC_OFF_MODE = 8'h00;
  localparam logic [7:0] PIC_OFF_START = 8'h04;
  localparam logic [7:0] PIC_OFF_STOP = 8'h08;
  localparam logic [7:0] PIC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] PIC_OFF_COUNT = 8'h10;
  localparam logic [7:0] PIC_OFF_DATA = 8'h14;
  localparam logic [7:0] PIC_OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] PIC_OFF_IRQ_MASK = 8'h1C;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int PIC_MODE_START_IRQ_BIT = 0;   // interrupt at start
  localparam int PIC_MODE_EDGE_LSB = 1;        // 2 bits edge select
  localparam int PIC_MODE_TRIG_LSB = 3;        // 2 bits trigger select
  localparam int PIC_MODE_PRESC_LSB = 5;       // 4 bits clock divider exponent
  localparam int PIC_MODE_WIDTH = 9;
  localparam logic [PIC_MODE_WIDTH-1:0] PIC_MODE_RESET = 9'h00A; // rising edge, pin trigger

  // edge selection codes
  localparam logic [1:0] PIC_EDGE_FALL = 2'h0;
  localparam logic [1:0] PIC_EDGE_RISE = 2'h1;
  localparam logic [1:0] PIC_EDGE_BOTH = 2'h2;

  // trigger selection codes
  localparam logic [1:0] PIC_TRIG_SOFT = 2'h0;
  localparam logic [1:0] PIC_TRIG_PIN = 2'h1;

  // interrupt status bits
  localparam int PIC_IRQ_CAPTURE = 0;
  localparam int PIC_IRQ_START = 1;
  localparam int PIC_IRQ_OVERFLOW = 2;
  localparam int PIC_IRQ_WIDTH = 3;

  // status register bits
  localparam int PIC_STAT_ENABLED = 0;
  localparam int PIC_STAT_OVF = 1;

  localparam logic [15:0] PIC_COUNT_ZERO = 16'h0000;
  localparam logic [31:0] PIC_RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // channel states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PIC_ST_IDLE = 3'b001,
    PIC_ST_WAIT = 3'b010,
    PIC_ST_COUNT = 3'b100
  } pic_state_type;

endpackage

// ### rtl/pic_edge_detect.sv
module pic_edge_detect
  import pic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  output logic edge_valid
);

  // ----------------------------------------------------------------
  // two-stage synchroniser, then one stage for edge history
  // ----------------------------------------------------------------
  logic sync1_r, sync2_r, hist_r;
  logic sync1_nxt, sync2_nxt, hist_nxt;

  // next-value logic for the pin pipeline
  always_comb begin
    sync1_nxt = sync1_r;
    sync2_nxt = sync2_r;
    hist_nxt = hist_r;
    if (clk_en) begin
      sync1_nxt = pin_in;
      sync2_nxt = sync1_r;
      hist_nxt = sync2_r;
    end
  end

  // register the pin pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      hist_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      hist_r <= hist_nxt;
    end
  end

  // valid edge decode by polarity selection
  always_comb begin
    case (edge_sel)
      PIC_EDGE_RISE: edge_valid = sync2_r & ~hist_r;
      PIC_EDGE_FALL: edge_valid = ~sync2_r & hist_r;
      PIC_EDGE_BOTH: edge_valid = sync2_r ^ hist_r;
      default: edge_valid = sync2_r ^ hist_r;
    endcase
    // a frozen pipeline must not repeat the same edge every cycle
    edge_valid = edge_valid & clk_en;
  end

endmodule // pic_edge_detect

// ### rtl/pic_prescaler.sv
module pic_prescaler
  import pic_pkg::*;
#(
  parameter int DIV_WIDTH = 15
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [3:0] presc_sel,
  output logic tick
);

  // ----------------------------------------------------------------
  // free-running divider, tick marks one operation clock
  // ----------------------------------------------------------------
  logic [DIV_WIDTH-1:0] div_r, div_nxt;
  logic [DIV_WIDTH:0] mask;

  // next divider value
  always_comb begin
    div_nxt = div_r;
    if (clk_en) begin
      div_nxt = div_r + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // register the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // tick when the selected low bits are all one; exponent zero gives pclk
  always_comb begin
    mask = ({{DIV_WIDTH{1'b0}}, 1'b1} << presc_sel) - {{DIV_WIDTH{1'b0}}, 1'b1};
    tick = clk_en & ((div_r & mask[DIV_WIDTH-1:0]) == mask[DIV_WIDTH-1:0]);
  end

endmodule // pic_prescaler

// ### test/pic_pulse_source.sv
module pic_pulse_source
(
  input wire logic pclk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // push-pull source, rests low between pulses
  initial pin = 1'b0;

  // rising edge now, high for 4 cycles, next rising edge gap cycles later
  task automatic send(input int gap);
    pin <= 1'b1;
    repeat (4) @(posedge pclk);
    pin <= 1'b0;
    repeat (gap - 4) @(posedge pclk);
  endtask
endmodule // pic_pulse_source

// ### test/pic_capture_channel_assertions.sv
module pic_capture_chk
  import pic_pkg::*;
#(
  parameter int CNT_WIDTH = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic capture_input_pin,
  input wire logic channel_timer_irq,
  input wire logic irq
);
  logic [6:0] ph;
  logic [3:0] sw;
  logic acc;

  // access phase of an apb transfer
  assign acc = psel && penable;

  // history of the pin and of start writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 7'h00;
      sw <= 4'h0;
    end else begin
      ph <= {ph[5:0], capture_input_pin};
      sw <= {sw[2:0], acc && pwrite && paddr == PIC_OFF_START && pwdata[0]};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_level: assert property (pready == clk_en)
    else $error("pready differs from clk_en");
  chk_irq_one_cycle: assert property (channel_timer_irq |=> !channel_timer_irq)
    else $error("channel irq longer than one cycle");
  chk_irq_cause: assert property (channel_timer_irq |-> ph[6:1] != ph[5:0] || sw != 4'h0)
    else $error("channel irq without pin edge or start");
  chk_slverr_bad: assert property (acc && paddr > PIC_OFF_IRQ_MASK |-> pslverr)
    else $error("unmapped access without error");
  chk_slverr_good: assert property (acc && paddr <= PIC_OFF_IRQ_MASK && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged as error");
  chk_rdata_bad: assert property (acc && !pwrite && paddr > PIC_OFF_IRQ_MASK |-> prdata == PIC_RDATA_ZERO)
    else $error("unmapped read not zero");
  chk_irq_clear: assert property (acc && pwrite && paddr == PIC_OFF_IRQ_STAT && pwdata[2:0] == 3'h7
    && ph == 7'h00 |-> ##2 !irq)
    else $error("irq still high after clearing");
  chk_quiet_reset: assert property ($rose(presetn) |-> !irq && !channel_timer_irq)
    else $error("interrupt active after reset");
endmodule // pic_capture_chk

bind pic_capture_channel pic_capture_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_input_pin(capture_input_pin),
  .channel_timer_irq(channel_timer_irq), .irq(irq));

// ### test/pulse_interval_capture_channel_tb_top.sv
module pulse_interval_capture_channel_tb_top
  import pic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pin, ctirq, irq, err;
  int mismatches = 0;
  int checks_done = 0;
  int pulses = 0;
  int cyc = 0;

  // 40 mhz clock
  always #12.5 pclk = ~pclk;

  pic_capture_channel #(.CNT_WIDTH(8)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_input_pin(pin), .channel_timer_irq(ctirq), .irq(irq));
  pic_pulse_source src (.pclk(pclk), .pin(pin));

  // count one-cycle channel interrupt pulses
  always @(negedge pclk) pulses += (ctirq === 1'b1);

  // -----------------------------
  // shared tasks
  // -----------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // access phase: sample pready, data and error at the same rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge pclk);
    check({31'h0000_0000, irq}, {31'h0000_0000, exp});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // -----------------------------
  // tests
  // -----------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(PIC_OFF_MODE, 32'h0000_000A);
    rd_chk(8'h40, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, PIC_OFF_IRQ_MASK, 32'h0000_0007);
    rd_chk(PIC_OFF_IRQ_MASK, 32'h0000_0007);
    $display("test registers done");
    apb(1'b1, PIC_OFF_START, 32'h0000_0001);
    rd_chk(PIC_OFF_COUNT, 32'h0000_0000);
    src.send(40);
    src.send(40);
    src.send(60);
    src.send(20);
    check(pulses, 3);
    rd_chk(PIC_OFF_DATA, 32'h0000_003B);
    rd_chk(PIC_OFF_IRQ_STAT, 32'h0000_0001);
    irq_chk(1'b1);
    apb(1'b1, PIC_OFF_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    irq_chk(1'b0);
    $display("test intervals done");
    apb(1'b1, PIC_OFF_STOP, 32'h0000_0001);
    apb(1'b1, PIC_OFF_MODE, 32'h0000_000B);
    apb(1'b1, PIC_OFF_START, 32'h0000_0001);
    src.send(300);
    src.send(10);
    check(pulses, 5);
    rd_chk(PIC_OFF_DATA, 32'h0000_002B);
    rd_chk(PIC_OFF_STATUS, 32'h0000_0003);
    rd_chk(PIC_OFF_IRQ_STAT, 32'h0000_0007);
    $display("test overflow done");
    // frozen block holds pready low
    clk_en <= 1'b0;
    repeat (4) @(posedge pclk);
    check({31'h0000_0000, pready}, 32'h0000_0000);
    check({31'h0000_0000, ctirq}, 32'h0000_0000);
    clk_en <= 1'b1;
    rd_chk(PIC_OFF_STATUS, 32'h0000_0003);
    $display("test enable done");
    give_verdict();
  end
endmodule // pulse_interval_capture_channel_tb_top
